// [rtl/rpt_params.svh]
// Timing counts, patterns and field positions of the packet repetition block.
// Assumes a 50 MHz system clock and a 10 Mb/s transmit bit rate.
`ifndef RPT_PARAMS_SVH
`define RPT_PARAMS_SVH

`define RPT_CLK_NS 20
`define RPT_BIT_NS 100
`define RPT_BIT_DIV ((`RPT_BIT_NS + `RPT_CLK_NS - 1) / `RPT_CLK_NS)
`define RPT_STARTUP_NS 1000
`define RPT_STARTUP_CYC ((`RPT_STARTUP_NS + `RPT_CLK_NS - 1) / `RPT_CLK_NS)
`define RPT_MIN_BITS 8'h60
`define RPT_PRE_BITS 8'h38
`define RPT_DATA_FIELD_BIT 8'h70
`define RPT_SFD_PATTERN 8'hAB
`define RPT_SFD_TAIL 2'h2
`define RPT_TW1_BITS 8'h10
`define RPT_TW2_BITS 8'h08
`define RPT_LFSR_SEED 15'h7FFF

`endif

// [rtl/rpt_pkg.sv]
// Types shared by the packet repetition block.
// Assumes rpt_params.svh carries all numeric constants.
package rpt_pkg;
  typedef enum logic [2:0] {
    RPT_IDLE = 3'h0,
    RPT_ARB = 3'h1,
    RPT_PRE = 3'h3,
    RPT_SFD = 3'h2,
    RPT_DATA = 3'h6,
    RPT_WAIT = 3'h4,
    RPT_RXCOL = 3'h7
  } rpt_state_e;
  typedef enum logic [1:0] {
    RPT_BUS_IDLE = 2'h0,
    RPT_BUS_REPEAT = 2'h1,
    RPT_BUS_RXCOL = 2'h2
  } rpt_bus_e;
  typedef struct packed {
    logic data;
    logic clk;
    logic frame;
  } rpt_serial_s;
endpackage

// [rtl/rpt_repeater.sv]
// Elasticity FIFO and main packet repetition control of one repeater device.
// Assumes pins and bus sense lines are asynchronous; CAM mismatch and secure
// mode inputs come from logic on sys_clk.
`timescale 1ns/10ps
`include "rpt_params.svh"

// ====================================================================
// Elasticity FIFO
module rpt_fifo #(
  parameter int W = 1,
  parameter int D = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = wr_valid & ~full & ~flush;
  wire pop = rd_ready & ~empty & ~flush;
  assign wr_ready = ~full;
  assign rd_valid = ~empty;
  assign rd_data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_q[wp_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else if (flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule

// ====================================================================
// Main repetition control
module rpt_repeater #(
  parameter int NP = 13,
  parameter int AUI_IDX = 12,
  parameter int FIFO_DEPTH = 32,
  parameter int FIFO_W = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic secure_mode,
  input wire logic [NP-1:0] da_mismatch,
  input wire logic sa_mismatch,
  input wire logic [NP-1:0] port_rx_active,
  input wire logic [NP-1:0] port_col_active,
  input wire logic dec_data,
  input wire logic dec_clk,
  input wire logic dec_lock,
  output logic [3:0] rx_mux_sel,
  input wire logic arb_chain_in_n,
  output logic arb_chain_out_n,
  input wire logic bus_activity_line_n_in,
  output logic bus_activity_line_n_out,
  output logic bus_activity_line_n_oe,
  input wire logic bus_collision_line_n_in,
  output logic bus_collision_line_n_out,
  output logic bus_collision_line_n_oe,
  input wire logic bus_serial_data_in,
  output logic bus_serial_data_out,
  output logic bus_serial_data_oe,
  input wire logic bus_bit_clock_in,
  output logic bus_bit_clock_out,
  output logic bus_bit_clock_oe,
  input wire logic bus_frame_enable_n_in,
  output logic bus_frame_enable_n_out,
  output logic bus_frame_enable_n_oe,
  output logic [NP-1:0] port_tx_en,
  output logic [NP-1:0] port_tx_data,
  output logic [1:0] bus_state,
  output logic elastic_buffer_error
);
  localparam int SW = 2 * NP + 9;

  // ==================================================================
  // Input synchronisers; active-low lines inverted ahead of the first stage
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  wire [SW-1:0] sync_in = {port_rx_active, port_col_active, dec_data, dec_clk, dec_lock,
                           ~arb_chain_in_n, ~bus_activity_line_n_in, ~bus_collision_line_n_in,
                           bus_serial_data_in, bus_bit_clock_in, ~bus_frame_enable_n_in};

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  wire [NP-1:0] rx_s = sync2_q[SW-1 -: NP];
  wire [NP-1:0] col_s = sync2_q[NP+8 -: NP];
  wire dec_data_s = sync2_q[8];
  wire dec_clk_s = sync2_q[7];
  wire dec_lock_s = sync2_q[6];
  wire chain_busy_s = sync2_q[5];
  wire act_s = sync2_q[4];
  wire coll_s = sync2_q[3];
  rpt_pkg::rpt_serial_s bus_in_s;
  assign bus_in_s = sync2_q[2:0];

  // ==================================================================
  // Local arbitration
  function automatic logic [3:0] first_port(input logic [NP-1:0] act);
    first_port = 4'h0;
    for (int i = NP - 1; i >= 0; i--)
    begin
      if (act[i])
      begin
        first_port = 4'(i);
      end
    end
  endfunction

  wire [NP-1:0] local_act = rx_s | col_s;
  wire local_any = |local_act;
  wire [3:0] local_win = first_port(local_act);
  wire local_claim = local_any & ~chain_busy_s;

  // ==================================================================
  // Bit rate enable and state registers
  rpt_pkg::rpt_state_e state_q;
  rpt_pkg::rpt_state_e state_d;
  logic [2:0] div_q;
  logic [7:0] startup_q;
  logic [7:0] bitcnt_q;
  logic [7:0] dcnt_q;
  logic [7:0] ext_q;
  logic [1:0] sfdcnt_q;
  logic owns_q;
  logic [3:0] owner_q;
  logic alt_q;
  logic err_q;
  logic col_seen_q;
  logic sfd_found_q;
  logic [7:0] shift_q;
  logic clk_prev_q;
  logic [14:0] lfsr_q;
  rpt_pkg::rpt_serial_s bus_out_q;
  logic act_drive_q;
  logic coll_drive_q;

  wire bit_en = (div_q == 3'(`RPT_BIT_DIV - 1));
  wire startup_done = (startup_q == 8'(`RPT_STARTUP_CYC - 1));
  wire min_done = (bitcnt_q >= `RPT_MIN_BITS);
  wire tw2_done = (ext_q >= `RPT_TW2_BITS);
  wire tw1_done = (ext_q >= (`RPT_TW1_BITS - 8'h01));
  wire is_pre = (state_q == rpt_pkg::RPT_PRE);
  wire is_data = (state_q == rpt_pkg::RPT_DATA);
  wire sending = is_pre || is_data || (state_q == rpt_pkg::RPT_SFD)
                 || (state_q == rpt_pkg::RPT_RXCOL);

  // ==================================================================
  // Bus receive path into the elasticity FIFO
  wire bus_edge = bus_in_s.clk & ~clk_prev_q;
  wire [7:0] shift_d = {shift_q[6:0], bus_in_s.data};
  wire sfd_hit = bus_edge & bus_in_s.frame & ~sfd_found_q & (shift_d == `RPT_SFD_PATTERN);
  wire fifo_wr = bus_edge & bus_in_s.frame & sfd_found_q & ~col_seen_q;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire [FIFO_W-1:0] fifo_rd_data;
  wire fifo_rd = bit_en & is_data;
  wire overflow = fifo_wr & ~fifo_wr_ready;
  wire underrun = is_data & ~fifo_rd_valid & sfd_found_q;
  wire jam_cond = coll_s | err_q | overflow | underrun;
  wire frame_over = ~fifo_rd_valid & ~sfd_found_q;

  rpt_fifo #(
    .W(FIFO_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .flush(state_q == rpt_pkg::RPT_IDLE),
    .wr_valid(fifo_wr),
    .wr_data(FIFO_W'(bus_in_s.data)),
    .wr_ready(fifo_wr_ready),
    .rd_valid(fifo_rd_valid),
    .rd_data(fifo_rd_data),
    .rd_ready(fifo_rd)
  );

  // ==================================================================
  // Main state machine
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      rpt_pkg::RPT_IDLE:
        if (act_s)
          state_d = rpt_pkg::RPT_ARB;
      rpt_pkg::RPT_ARB:
        if (startup_done)
          state_d = rpt_pkg::RPT_PRE;
      rpt_pkg::RPT_PRE:
        if (bit_en)
        begin
          if (jam_cond || (!act_s && frame_over))
            state_d = rpt_pkg::RPT_RXCOL;
          else if (bitcnt_q >= `RPT_PRE_BITS && fifo_rd_valid && !alt_q)
            state_d = rpt_pkg::RPT_SFD;
        end
      rpt_pkg::RPT_SFD:
        if (bit_en)
        begin
          if (jam_cond)
            state_d = rpt_pkg::RPT_RXCOL;
          else if (sfdcnt_q == `RPT_SFD_TAIL - 2'h1)
            state_d = rpt_pkg::RPT_DATA;
        end
      rpt_pkg::RPT_DATA:
        if (bit_en)
        begin
          if (jam_cond)
            state_d = rpt_pkg::RPT_RXCOL;
          else if (frame_over)
            state_d = min_done ? rpt_pkg::RPT_WAIT : rpt_pkg::RPT_RXCOL;
        end
      rpt_pkg::RPT_RXCOL:
        if (bit_en && min_done && tw2_done && !coll_s && !act_s)
          state_d = rpt_pkg::RPT_WAIT;
      rpt_pkg::RPT_WAIT:
        if (bit_en && tw1_done)
          state_d = rpt_pkg::RPT_IDLE;
      default:
        state_d = rpt_pkg::RPT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= rpt_pkg::RPT_IDLE;
      div_q <= 3'h0;
      startup_q <= 8'h00;
      owns_q <= 1'b0;
      owner_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      div_q <= bit_en ? 3'h0 : div_q + 3'h1;
      startup_q <= (state_q == rpt_pkg::RPT_ARB) ? startup_q + 8'h01 : 8'h00;
      if (state_q == rpt_pkg::RPT_ARB && startup_done)
      begin
        owns_q <= local_claim;
        owner_q <= local_win;
      end
      else if (state_q == rpt_pkg::RPT_IDLE)
      begin
        owns_q <= 1'b0;
      end
    end
  end

  // Bit time counters, all stepped by the transmit bit enable
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bitcnt_q <= 8'h00;
      dcnt_q <= 8'h00;
      ext_q <= 8'h00;
      sfdcnt_q <= 2'h0;
      alt_q <= 1'b1;
    end
    else if (state_q == rpt_pkg::RPT_IDLE || state_q == rpt_pkg::RPT_ARB)
    begin
      bitcnt_q <= 8'h00;
      dcnt_q <= 8'h00;
      ext_q <= 8'h00;
      sfdcnt_q <= 2'h0;
      alt_q <= 1'b1;
    end
    else if (bit_en)
    begin
      if (bitcnt_q != 8'hFF)
        bitcnt_q <= bitcnt_q + 8'h01;
      if (is_data && dcnt_q != 8'hFF)
        dcnt_q <= dcnt_q + 8'h01;
      if (state_q == rpt_pkg::RPT_SFD)
        sfdcnt_q <= sfdcnt_q + 2'h1;
      alt_q <= ~alt_q;
      if (state_d != state_q || (state_q == rpt_pkg::RPT_RXCOL && coll_s))
        ext_q <= 8'h00;
      else if (ext_q != 8'hFF)
        ext_q <= ext_q + 8'h01;
    end
  end

  // Frame search, collision latch and error flag; set wins over clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_q <= 8'h00;
      sfd_found_q <= 1'b0;
      clk_prev_q <= 1'b0;
      col_seen_q <= 1'b0;
      err_q <= 1'b0;
      lfsr_q <= `RPT_LFSR_SEED;
    end
    else
    begin
      clk_prev_q <= bus_in_s.clk;
      if (bus_edge)
        shift_q <= shift_d;
      if (sfd_hit)
        sfd_found_q <= 1'b1;
      else if (!bus_in_s.frame)
        sfd_found_q <= 1'b0;
      if (coll_s)
        col_seen_q <= 1'b1;
      else if (state_q == rpt_pkg::RPT_IDLE)
        col_seen_q <= 1'b0;
      if (overflow || underrun)
        err_q <= 1'b1;
      else if (state_q == rpt_pkg::RPT_IDLE)
        err_q <= 1'b0;
      if (bit_en)
        lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
    end
  end

  // ==================================================================
  // Bus drive while holding the receiving port
  wire sa_scramble = secure_mode & sa_mismatch;
  wire owner_rx = rx_s[owner_q];
  wire owner_col = col_s[owner_q];
  wire act_drive_d = (state_q == rpt_pkg::RPT_IDLE || state_q == rpt_pkg::RPT_ARB)
                     ? local_claim : (owns_q & (owner_rx | owner_col));

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_out_q <= '0;
      act_drive_q <= 1'b0;
      coll_drive_q <= 1'b0;
      arb_chain_out_n <= 1'b1;
    end
    else
    begin
      bus_out_q.clk <= dec_clk_s;
      bus_out_q.data <= sa_scramble ? lfsr_q[0] : dec_data_s;
      bus_out_q.frame <= owns_q & dec_lock_s & owner_rx;
      act_drive_q <= act_drive_d;
      coll_drive_q <= owns_q & (owner_q == 4'(AUI_IDX)) & owner_col;
      arb_chain_out_n <= ~(chain_busy_s | local_any);
    end
  end

  // The decoder stays on the local winner once this device wins arbitration; otherwise it follows local_win
  assign rx_mux_sel = owns_q ? owner_q : local_win;
  assign bus_activity_line_n_out = 1'b0;
  assign bus_activity_line_n_oe = act_drive_q;
  assign bus_collision_line_n_out = 1'b0;
  assign bus_collision_line_n_oe = coll_drive_q;
  wire bus_drive = owns_q & dec_lock_s;
  assign bus_serial_data_out = bus_out_q.data;
  assign bus_serial_data_oe = bus_drive;
  assign bus_bit_clock_out = bus_out_q.clk;
  assign bus_bit_clock_oe = bus_drive;
  assign bus_frame_enable_n_out = ~bus_out_q.frame;
  assign bus_frame_enable_n_oe = bus_drive;
  assign elastic_buffer_error = err_q;

  // Merged state as the bus shows it
  assign bus_state = (state_q == rpt_pkg::RPT_RXCOL) ? rpt_pkg::RPT_BUS_RXCOL
                   : (is_pre || is_data || state_q == rpt_pkg::RPT_SFD)
                   ? rpt_pkg::RPT_BUS_REPEAT : rpt_pkg::RPT_BUS_IDLE;

  // ==================================================================
  // Per-port transmit; preamble and jam share the alternating generator
  wire data_field = dcnt_q >= `RPT_DATA_FIELD_BIT;
  wire tx_bit = is_data ? fifo_rd_data[0]
              : (state_q == rpt_pkg::RPT_SFD) ? 1'b1 : alt_q;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_port
      wire scramble = is_data & secure_mode & ((da_mismatch[gi] & data_field) | sa_mismatch);
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          port_tx_en[gi] <= 1'b0;
          port_tx_data[gi] <= 1'b0;
        end
        else if (bit_en)
        begin
          port_tx_en[gi] <= sending & ~(owns_q & (owner_q == 4'(gi)));
          port_tx_data[gi] <= scramble ? lfsr_q[0] : tx_bit;
        end
      end
    end
  endgenerate

  // ==================================================================
  // Checks
  arb_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (chain_busy_s | local_any) |=> !arb_chain_out_n)
    else $error("chain output not pulled low on activity");

  startup_len_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == rpt_pkg::RPT_ARB && state_d == rpt_pkg::RPT_PRE) |-> startup_done)
    else $error("start-up delay cut short");

  pre_enough_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(state_q == rpt_pkg::RPT_SFD) |-> $past(bitcnt_q) >= `RPT_PRE_BITS)
    else $error("data started before enough preamble");

  rxcol_exit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == rpt_pkg::RPT_RXCOL) ##1 (state_q == rpt_pkg::RPT_WAIT)
    |-> $past(min_done) && $past(!act_s))
    else $error("receive collision left too early");

  ext_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == rpt_pkg::RPT_RXCOL && state_d == rpt_pkg::RPT_WAIT) |-> tw2_done && !coll_s)
    else $error("collision extension not completed");

  jam_switch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (is_data && bit_en && coll_s) |=> state_q == rpt_pkg::RPT_RXCOL)
    else $error("collision did not switch to jam");

  err_like_col_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (err_q && bit_en && (is_pre || is_data)) |=> state_q == rpt_pkg::RPT_RXCOL)
    else $error("buffer error not handled as collision");

  sfd_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fifo_wr |-> sfd_found_q && !col_seen_q)
    else $error("buffer written before frame delimiter");

  wait_tw1_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == rpt_pkg::RPT_WAIT && state_d == rpt_pkg::RPT_IDLE) |-> tw1_done)
    else $error("recovery time cut short");

  bus_view_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (is_pre || is_data) |-> bus_state == rpt_pkg::RPT_BUS_REPEAT)
    else $error("bus state not shown as repeat");

  bus_data_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !sa_scramble |=> bus_out_q.data == $past(dec_data_s))
    else $error("bus data altered without source mismatch");
endmodule

// [test/rpt_peer.sv]
// Model of a cascaded repeater that sits above the device in the arbitration chain.
// Assumes the bench resolves the open-drain lines and selects bus drivers by enable.
`timescale 1ns/10ps
module rpt_peer (
  input wire logic start,
  output logic arb_n,
  output logic act_pull,
  output logic col_pull,
  output logic data,
  output logic clk,
  output logic fen_n
);
  // ====================================================================
  // One bit per 160 ns; data changes on the falling clock edge
  task automatic send_bit(input logic b);
    data = b;
    #80;
    clk = 1'b1;
    #80;
    clk = 1'b0;
  endtask

  initial
  begin
    arb_n = 1'b1;
    act_pull = 1'b0;
    col_pull = 1'b0;
    data = 1'b0;
    clk = 1'b0;
    fen_n = 1'b1;
  end

  // ====================================================================
  // Frame: preamble, start delimiter, short payload
  always @(posedge start)
  begin
    #7;
    arb_n = 1'b0;
    act_pull = 1'b1;
    #1500;
    fen_n = 1'b0;
    for (int i = 0; i < 62; i++)
      send_bit(~i[0]);
    send_bit(1'b1);
    send_bit(1'b1);
    for (int i = 0; i < 40; i++)
      send_bit(i % 3 == 0);
    fen_n = 1'b1;
    arb_n = 1'b1;
    act_pull = 1'b0;
    // Released line must not look like held data
    data = ~data;
  end
endmodule

// [test/repeater_packet_repetition_test.sv]
// Self-checking bench of the packet repetition block with one peer repeater.
// Assumes rpt_repeater at its default port count, AUI on the top index.
`timescale 1ns/10ps
module repeater_packet_repetition_test;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [12:0] rx_act = '0;
  logic [12:0] col_act = '0;
  logic dec_data = 1'b0;
  logic dec_clk = 1'b0;
  logic dec_lock = 1'b0;
  logic peer_go = 1'b0;
  logic [3:0] rx_mux_sel;
  logic arb_out_n, act_out, act_oe, col_out, col_oe, sd_out, sd_oe, bc_out, bc_oe;
  logic fe_out, fe_oe, eb_err, p_arb_n, p_act, p_col, p_data, p_clk, p_fen_n;
  logic [12:0] tx_en, tx_data;
  logic [1:0] bus_state;
  logic [1:0] exp_state[$];
  logic exp_bit[$];
  logic mon_on = 1'b0;
  logic p;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 32'h10f3;
  int n;

  always #10 sys_clk = ~sys_clk;

  rpt_repeater rpt_repeater_inst (.sys_clk(sys_clk), .resetn(resetn), .secure_mode(1'b0),
    .da_mismatch(13'h0000), .sa_mismatch(1'b0), .port_rx_active(rx_act),
    .port_col_active(col_act), .dec_data(dec_data), .dec_clk(dec_clk), .dec_lock(dec_lock),
    .rx_mux_sel(rx_mux_sel), .arb_chain_in_n(p_arb_n), .arb_chain_out_n(arb_out_n),
    .bus_activity_line_n_in(~(act_oe | p_act)), .bus_activity_line_n_out(act_out),
    .bus_activity_line_n_oe(act_oe), .bus_collision_line_n_in(~(col_oe | p_col)),
    .bus_collision_line_n_out(col_out), .bus_collision_line_n_oe(col_oe),
    .bus_serial_data_in(sd_oe ? sd_out : p_data), .bus_serial_data_out(sd_out),
    .bus_serial_data_oe(sd_oe), .bus_bit_clock_in(bc_oe ? bc_out : p_clk),
    .bus_bit_clock_out(bc_out), .bus_bit_clock_oe(bc_oe),
    .bus_frame_enable_n_in(fe_oe ? fe_out : p_fen_n), .bus_frame_enable_n_out(fe_out),
    .bus_frame_enable_n_oe(fe_oe), .port_tx_en(tx_en), .port_tx_data(tx_data),
    .bus_state(bus_state), .elastic_buffer_error(eb_err));

  rpt_peer rpt_peer_inst (.start(peer_go), .arb_n(p_arb_n), .act_pull(p_act),
    .col_pull(p_col), .data(p_data), .clk(p_clk), .fen_n(p_fen_n));

  // ====================================================================
  // Compare and closing tasks
  task automatic cmp_val(input logic [15:0] e, input logic [15:0] a);
    comparisons++;
    if (a !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task automatic cmp_state(input logic [1:0] e, input logic [1:0] a);
    cmp_val({14'h0000, e}, {14'h0000, a});
  endtask

  task automatic cmp_bit(input logic e, input logic a);
    cmp_val({15'h0000, e}, {15'h0000, a});
  endtask

  task automatic summarize();
    mismatches += exp_state.size();
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic dec_bit(input logic b);
    dec_data = b;
    dec_clk = 1'b0;
    repeat (2) @(negedge sys_clk);
    dec_clk = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  // Bus idle, then the wait state's 16 recovery bits
  task automatic wait_idle();
    for (int i = 0; i < 6000 && bus_state !== 2'h0; i++)
      @(negedge sys_clk);
    repeat (100) @(negedge sys_clk);
  endtask

  // ====================================================================
  // Watchers: bus state changes and repeated bits on port 1
  always @(bus_state)
    if (resetn === 1'b1)
      cmp_state(exp_state.size() > 0 ? exp_state.pop_front() : 2'h3, bus_state);

  initial
  forever
  begin
    @(posedge tx_en[1]);
    if (mon_on)
    begin
      repeat (2) @(negedge sys_clk);
      cmp_bit(1'b1, tx_data[1]);
      repeat (5) @(negedge sys_clk);
      cmp_bit(1'b0, tx_data[1]);
      n = 2;
      p = 1'b0;
      // Two ones in a row mark the delimiter tail; preamble never repeats a one
      while (n < 400 && !(p === 1'b1 && tx_data[1] === 1'b1 && n > 2))
      begin
        p = tx_data[1];
        repeat (5) @(negedge sys_clk);
        n++;
      end
      cmp_bit(1'b1, n >= 58);
      while (exp_bit.size() > 0)
      begin
        repeat (5) @(negedge sys_clk);
        cmp_bit(exp_bit.pop_front(), tx_data[1]);
      end
    end
  end

  initial
  begin
    #500000;
    mismatches++;
    summarize();
  end

  // ====================================================================
  // Scenarios
  initial
  begin
    logic [31:0] r;
    repeat (5) @(negedge sys_clk);
    cmp_val(16'h0001, {act_oe, tx_en[0], bus_state, eb_err, arb_out_n});
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (3) @(negedge sys_clk);
    // Local packet on port 3, looped through the bus
    exp_state = '{2'h1, 2'h0};
    rx_act[3] = 1'b1;
    mon_on = 1'b1;
    repeat (5) @(negedge sys_clk);
    cmp_val(16'h0001, {arb_out_n, act_oe});
    dec_lock = 1'b1;
    for (int i = 0; i < 62; i++)
      dec_bit(~i[0]);
    dec_bit(1'b1);
    dec_bit(1'b1);
    for (int i = 0; i < 120; i++)
    begin
      r = $random(seed);
      exp_bit.push_back(r[0]);
      dec_bit(r[0]);
    end
    cmp_bit(1'b1, sd_oe);
    dec_lock = 1'b0;
    rx_act[3] = 1'b0;
    wait_idle();
    mon_on = 1'b0;
    // Two ports at once, too short: fragment extension
    exp_state = '{2'h1, 2'h2, 2'h0};
    rx_act[5] = 1'b1;
    rx_act[7] = 1'b1;
    n = 0;
    for (int i = 0; i < 3000 && (i < 110 || bus_state !== 2'h0); i++)
    begin
      @(negedge sys_clk);
      if (i == 90)
        cmp_val(16'h1502, {rx_mux_sel, tx_en[5], tx_en[7], 6'h00, 2'h2});
      if (i == 100)
        rx_act = '0;
      n += int'(tx_en[0]);
    end
    cmp_bit(1'b1, n >= 480);
    repeat (100) @(negedge sys_clk);
    // Receive collision on the AUI port
    exp_state = '{2'h1, 2'h2, 2'h0};
    rx_act[12] = 1'b1;
    repeat (200) @(negedge sys_clk);
    col_act[12] = 1'b1;
    repeat (10) @(negedge sys_clk);
    cmp_bit(1'b1, col_oe);
    repeat (100) @(negedge sys_clk);
    r[0] = tx_data[0];
    repeat (5) @(negedge sys_clk);
    cmp_bit(~r[0], tx_data[0]);
    col_act[12] = 1'b0;
    rx_act[12] = 1'b0;
    n = 0;
    while (n < 3000 && bus_state !== 2'h0)
    begin
      @(negedge sys_clk);
      n++;
    end
    cmp_bit(1'b1, n >= 40);
    repeat (100) @(negedge sys_clk);
    // Peer owns the bus; its slow clock starves the buffer
    exp_state = '{2'h1, 2'h2, 2'h0};
    peer_go = 1'b1;
    repeat (400) @(negedge sys_clk);
    cmp_val(16'h1FFF, {3'h0, tx_en});
    cmp_val(16'h0000, {arb_out_n, sd_oe});
    for (int i = 0; i < 3000 && eb_err !== 1'b1; i++)
      @(negedge sys_clk);
    cmp_bit(1'b1, eb_err);
    wait_idle();
    peer_go = 1'b0;
    summarize();
  end
endmodule
